// ==== hw/serial_ctrl_consts.vh ====
`ifndef SERIAL_CTRL_CONSTS_VH
`define SERIAL_CTRL_CONSTS_VH
`define WORD_BITS 16
`define REG_ADDR_RESET 7'h00
`define REG_ADDR_GPIO_LOW 7'h08
`define REG_ADDR_JACK_CFG 7'h09
`define REG_ADDR_JACK_EN 7'h0d
`define BUS_ADDR_2W 7'h1a
`define RST_JACK_CFG 9'h000
`define RST_JACK_EN 9'h000
`define RST_GPIO_LOW 9'h000
`define DET_SRC_LSB 4
`define DET_ENABLE_BIT 6
`define MID_LOW_BIT 7
`define MID_HIGH_BIT 8
`define JE_SPK0_BIT 1
`define JE_MONO0_BIT 2
`define JE_SPK1_BIT 5
`define JE_MONO1_BIT 6
`define SRC_PIN_ONE 2'b00
`define SRC_LINE_IN 2'b01
`define SRC_PIN_TWO 2'b11
`define SLOW_TICK_LOG2 21
`endif

// ==== hw/serial_control_and_jack_detect.v ====
// Function
// - Mode pin low two-wire, high three-wire.
// - Word: seven address bits, nine data bits.
// - Three-wire shifts data on clock rise.
// - Latch rise stores last sixteen bits.
// - Three-wire: shared pin is latch only.
// - Two-wire slave; start is data fall.
// - After start, eight bits MSB first.
// - Fixed bus address binary 0011010.
// - Matching address acknowledged by pulling low.
// - Mismatch or read bit goes idle.
// - Upper then lower byte, each acknowledged.
// - Stop is data rise; return idle.
// - Unexpected start or stop aborts transfer.
// - Write to address zero restores defaults.
// - Power-on reset loads all defaults.
// - Bits 5:4 choose detect source pin.
// - Bit six enables jack detection.
// - Debounce on 2^21 master-clock slow tick.
// - Raw pin level used, no inversion.
// - Low field or high field by level.
// - Output enable ANDs normal and jack.
// - Midrail enable ORs normal and jack.
// - Detection off: enables one, midrail zero.
`timescale 1ns/1ps
`include "serial_ctrl_consts.vh"
module serial_control_and_jack_detect #(
  parameter TICK_LOG2 = `SLOW_TICK_LOG2
) (
  input wire ref_clk,
  input wire rst,
  input wire mode_pin,
  input wire ctrl_clk_pin,
  input wire ctrl_data_pin,
  output reg ctrl_data_out,
  output reg ctrl_data_oe,
  input wire latch_or_io_one_pin,
  input wire line_in_detect_pin,
  input wire io_pin_two,
  input wire spk_normal_en,
  input wire mono_normal_en,
  input wire midrail_normal_en,
  output reg speaker_output_en,
  output reg mono_output_en,
  output reg midrail_reference_en,
  output reg [8:0] jack_detect_config,
  output reg [8:0] jack_state_output_enables,
  output reg [8:0] io_low_config,
  output reg jack_level
);
  // ----------------------------------------
  // Pin synchronisers.
  // ----------------------------------------
  // Async pins pass three stages; the second and third must agree to count.
  reg [2:0] s_mode, s_clk, s_dat, s_lat, s_lin, s_io2;
  reg mode_q, clk_q, dat_q, lat_q, lin_q, io2_q;
  always @(posedge ref_clk) begin
    s_mode <= {s_mode[1:0], mode_pin};
    s_clk <= {s_clk[1:0], ctrl_clk_pin};
    s_dat <= {s_dat[1:0], ctrl_data_pin};
    s_lat <= {s_lat[1:0], latch_or_io_one_pin};
    s_lin <= {s_lin[1:0], line_in_detect_pin};
    s_io2 <= {s_io2[1:0], io_pin_two};
    if (rst) begin
      mode_q <= 1'b0;
      clk_q <= 1'b0;
      dat_q <= 1'b1;
      lat_q <= 1'b0;
      lin_q <= 1'b0;
      io2_q <= 1'b0;
    end else begin
      if (s_mode[1] == s_mode[2]) mode_q <= s_mode[2];
      if (s_clk[1] == s_clk[2]) clk_q <= s_clk[2];
      if (s_dat[1] == s_dat[2]) dat_q <= s_dat[2];
      if (s_lat[1] == s_lat[2]) lat_q <= s_lat[2];
      if (s_lin[1] == s_lin[2]) lin_q <= s_lin[2];
      if (s_io2[1] == s_io2[2]) io2_q <= s_io2[2];
    end
  end
  reg clk_p_q, dat_p_q, lat_p_q;
  always @(posedge ref_clk) begin
    if (rst) begin
      clk_p_q <= 1'b0;
      dat_p_q <= 1'b1;
      lat_p_q <= 1'b0;
    end else begin
      clk_p_q <= clk_q;
      dat_p_q <= dat_q;
      lat_p_q <= lat_q;
    end
  end
  wire scl_rise = clk_q & ~clk_p_q;
  wire scl_fall = ~clk_q & clk_p_q;
  wire three_wire = mode_q;
  wire start_cond = ~three_wire & clk_q & clk_p_q & dat_p_q & ~dat_q;
  wire stop_cond = ~three_wire & clk_q & clk_p_q & ~dat_p_q & dat_q;
  // ----------------------------------------
  // Three-wire shift path.
  // ----------------------------------------
  reg [15:0] sh3_q;
  always @(posedge ref_clk) begin
    if (rst) sh3_q <= 16'h0000;
    else if (three_wire && scl_rise) sh3_q <= {sh3_q[14:0], dat_q};
  end
  // Shared pin is read as latch in three-wire mode regardless of function select.
  wire latch_rise = three_wire & lat_q & ~lat_p_q;
  // ----------------------------------------
  // Two-wire slave.
  // ----------------------------------------
  localparam ST_IDLE = 5'b00001;
  localparam ST_ADDR = 5'b00010;
  localparam ST_ACK = 5'b00100;
  localparam ST_DATA = 5'b01000;
  localparam ST_WAIT = 5'b10000;
  reg [4:0] st_q;
  reg [3:0] cnt_q;
  reg [7:0] sh2_q;
  reg [1:0] phase_q;
  reg [15:0] word2_q;
  reg ack_on_q;
  reg wr2_q;
  always @(posedge ref_clk) begin
    if (rst) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh2_q <= 8'h00;
      phase_q <= 2'b00;
      word2_q <= 16'h0000;
      ack_on_q <= 1'b0;
      wr2_q <= 1'b0;
    end else begin
      wr2_q <= 1'b0;
      if (three_wire) begin
        st_q <= ST_IDLE;
        ack_on_q <= 1'b0;
      end else if (start_cond) begin
        st_q <= ST_ADDR;
        cnt_q <= 4'h0;
        ack_on_q <= 1'b0;
        phase_q <= 2'b00;
      end else if (stop_cond) begin
        st_q <= ST_IDLE;
        ack_on_q <= 1'b0;
      end else begin
        case (st_q)
          ST_ADDR, ST_DATA: begin
            if (scl_rise) begin
              sh2_q <= {sh2_q[6:0], dat_q};
              cnt_q <= cnt_q + 4'h1;
            end
            if (scl_fall && cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              if (phase_q == 2'b00) begin
                if (sh2_q == {`BUS_ADDR_2W, 1'b0}) begin
                  ack_on_q <= 1'b1;
                  st_q <= ST_ACK;
                end else begin
                  st_q <= ST_IDLE;
                end
              end else begin
                if (phase_q == 2'b01) word2_q[15:8] <= sh2_q;
                else word2_q[7:0] <= sh2_q;
                ack_on_q <= 1'b1;
                st_q <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              ack_on_q <= 1'b0;
              if (phase_q == 2'b10) begin
                wr2_q <= 1'b1;
                st_q <= ST_WAIT;
              end else begin
                phase_q <= phase_q + 2'b01;
                st_q <= ST_DATA;
              end
            end
          end
          ST_WAIT: st_q <= ST_WAIT;
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end
  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl_data_out <= 1'b0;
      ctrl_data_oe <= 1'b0;
    end else begin
      ctrl_data_out <= 1'b0;
      ctrl_data_oe <= ack_on_q & ~three_wire;
    end
  end
  // ----------------------------------------
  // Register file.
  // ----------------------------------------
  wire wr_any = latch_rise | wr2_q;
  wire [15:0] word = three_wire ? sh3_q : word2_q;
  wire [6:0] w_addr = word[15:9];
  wire [8:0] w_data = word[8:0];
  always @(posedge ref_clk) begin
    if (rst) begin
      jack_detect_config <= `RST_JACK_CFG;
      jack_state_output_enables <= `RST_JACK_EN;
      io_low_config <= `RST_GPIO_LOW;
    end else if (wr_any) begin
      if (w_addr == `REG_ADDR_RESET) begin
        jack_detect_config <= `RST_JACK_CFG;
        jack_state_output_enables <= `RST_JACK_EN;
        io_low_config <= `RST_GPIO_LOW;
      end else if (w_addr == `REG_ADDR_JACK_CFG) begin
        jack_detect_config <= w_data;
      end else if (w_addr == `REG_ADDR_JACK_EN) begin
        jack_state_output_enables <= w_data;
      end else if (w_addr == `REG_ADDR_GPIO_LOW) begin
        io_low_config <= w_data;
      end
    end
  end
  // ----------------------------------------
  // Jack detect.
  // ----------------------------------------
  wire det_on = jack_detect_config[`DET_ENABLE_BIT];
  wire [1:0] src = jack_detect_config[`DET_SRC_LSB+1:`DET_SRC_LSB];
  reg det_raw;
  always @* begin
    // Raw levels only; invert bits are deliberately ignored.
    if (src == `SRC_PIN_ONE) det_raw = three_wire ? 1'b0 : lat_q;
    else if (src == `SRC_LINE_IN) det_raw = lin_q;
    else if (src == `SRC_PIN_TWO) det_raw = io2_q;
    else det_raw = 1'b0;
  end
  // Slow tick trades response time for immunity to contact bounce.
  reg [TICK_LOG2-1:0] tick_cnt_q;
  reg [1:0] db_q;
  always @(posedge ref_clk) begin
    if (rst) begin
      tick_cnt_q <= {TICK_LOG2{1'b0}};
      db_q <= 2'b00;
      jack_level <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_q + {{(TICK_LOG2-1){1'b0}}, 1'b1};
      if (&tick_cnt_q) begin
        db_q <= {db_q[0], det_raw};
        if (db_q[0] == det_raw) jack_level <= det_raw;
      end
    end
  end
  wire [8:0] je = jack_state_output_enables;
  wire jspk = ~det_on | (jack_level ? je[`JE_SPK1_BIT] : je[`JE_SPK0_BIT]);
  wire jmono = ~det_on | (jack_level ? je[`JE_MONO1_BIT] : je[`JE_MONO0_BIT]);
  wire jmid = det_on & (jack_level ? jack_detect_config[`MID_HIGH_BIT]
                                   : jack_detect_config[`MID_LOW_BIT]);
  always @(posedge ref_clk) begin
    if (rst) begin
      speaker_output_en <= 1'b0;
      mono_output_en <= 1'b0;
      midrail_reference_en <= 1'b0;
    end else begin
      speaker_output_en <= spk_normal_en & jspk;
      mono_output_en <= mono_normal_en & jmono;
      midrail_reference_en <= midrail_normal_en | jmid;
    end
  end
endmodule

// ==== test/serial_ctrl_assertions.sv ====
`timescale 1ns/1ps
module serial_ctrl_checker (
  input wire ref_clk,
  input wire rst,
  input wire mode_pin,
  input wire spk_normal_en,
  input wire mono_normal_en,
  input wire midrail_normal_en,
  input wire ctrl_data_out,
  input wire ctrl_data_oe,
  input wire speaker_output_en,
  input wire mono_output_en,
  input wire midrail_reference_en,
  input wire [8:0] jack_detect_config,
  input wire [8:0] jack_state_output_enables
);
  // ----
  // Checks.
  // ----
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  AST_ACK_LOW: assert property (ctrl_data_oe |-> !ctrl_data_out)
    else $error("ack drives high");
  AST_ACK_LEN: assert property ($rose(ctrl_data_oe) |-> ctrl_data_oe[*4] ##[1:40] !ctrl_data_oe)
    else $error("ack length wrong");
  AST_ACK_3W: assert property (mode_pin && $past(mode_pin, 8) |-> !ctrl_data_oe)
    else $error("ack in three-wire mode");
  AST_SPK_AND: assert property (!$past(rst) && speaker_output_en |-> $past(spk_normal_en))
    else $error("speaker on without normal enable");
  AST_MONO_AND: assert property (!$past(rst) && mono_output_en |-> $past(mono_normal_en))
    else $error("mono on without normal enable");
  AST_MID_OR: assert property (!$past(rst) && $past(midrail_normal_en) |-> midrail_reference_en)
    else $error("midrail off despite normal enable");
  AST_DET_OFF: assert property (!$past(rst) && !$past(jack_detect_config[6]) |->
    speaker_output_en == $past(spk_normal_en) && mono_output_en == $past(mono_normal_en)
    && midrail_reference_en == $past(midrail_normal_en)) else $error("detect off not transparent");
  AST_RESET_CLR: assert property (disable iff (1'b0) $past(rst) |-> !speaker_output_en &&
    jack_detect_config == 9'h000 && jack_state_output_enables == 9'h000)
    else $error("reset did not clear");
endmodule
bind serial_control_and_jack_detect serial_ctrl_checker chk (.ref_clk, .rst, .mode_pin,
  .spk_normal_en, .mono_normal_en, .midrail_normal_en, .ctrl_data_out, .ctrl_data_oe,
  .speaker_output_en, .mono_output_en, .midrail_reference_en, .jack_detect_config,
  .jack_state_output_enables);

// ==== test/ctrl_host_model.sv ====
`timescale 1ns/1ps
module ctrl_host_model (
  output logic clk_pin = 1'b1,
  output logic data_drv = 1'b1,
  output logic latch_pin = 1'b0,
  input wire data_line
);
  // ----
  // Controller.
  // ----
  localparam int H = 24;
  task automatic write3(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      clk_pin = 1'b0;
      data_drv = w[i];
      #H;
      clk_pin = 1'b1;
      #H;
    end
    latch_pin = 1'b1;
    #H;
    latch_pin = 1'b0;
    // Data is not held after the frame, so a stale bit cannot pass for a good one.
    data_drv = ~data_drv;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      data_drv = b[i];
      #H;
      clk_pin = 1'b1;
      #H;
      clk_pin = 1'b0;
    end
    data_drv = 1'b1;
    #H;
    clk_pin = 1'b1;
    #H;
    // Sample the acknowledge late in the high phase; it shows only after pin synchronising.
    ack = !data_line;
    clk_pin = 1'b0;
  endtask
  task automatic write2(input logic [7:0] a, input logic [15:0] w, input int n,
                        output logic [2:0] acks);
    acks = 3'b000;
    data_drv = 1'b1;
    #H;
    data_drv = 1'b0;
    #H;
    clk_pin = 1'b0;
    send_byte(a, acks[2]);
    if (n > 0) send_byte(w[15:8], acks[1]);
    if (n > 1) send_byte(w[7:0], acks[0]);
    data_drv = 1'b0;
    #H;
    clk_pin = 1'b1;
    #H;
    data_drv = 1'b1;
    #H;
  endtask
endmodule

// ==== test/tb_serial_control_and_jack_detect.sv ====
`timescale 1ns/1ps
module tb_serial_control_and_jack_detect;
  typedef struct {logic m; logic [7:0] ba; logic [15:0] w; int n; logic [2:0] ea;
    logic [8:0] e9; logic [8:0] e13;} row_t;
  logic ref_clk = 1'b0, rst = 1'b1, mode_pin = 1'b1, pin_one = 1'b0, line_in = 1'b0;
  logic pin_two = 1'b0, spk_n = 1'b1, mono_n = 1'b1, mid_n = 1'b0;
  logic [2:0] acks;
  wire scl, sda_drv, latch, oe, spk, mono, mid, lvl;
  wire [8:0] r9, r13, io_low;
  wire sda = sda_drv & !oe;
  int fails = 0, comparisons = 0, cycles = 0;
  row_t rows[8] = '{'{1'b1, 8'h00, {7'h09, 9'h055}, 2, 3'b000, 9'h055, 9'h000},
    '{1'b1, 8'h00, {7'h08, 9'h007}, 2, 3'b000, 9'h055, 9'h000},
    '{1'b1, 8'h00, {7'h0d, 9'h022}, 2, 3'b000, 9'h055, 9'h022},
    '{1'b0, 8'h34, {7'h09, 9'h0f0}, 2, 3'b111, 9'h0f0, 9'h022},
    '{1'b0, 8'h35, {7'h0d, 9'h1ff}, 2, 3'b000, 9'h0f0, 9'h022},
    '{1'b0, 8'h36, {7'h09, 9'h000}, 2, 3'b000, 9'h0f0, 9'h022},
    '{1'b0, 8'h34, {7'h0d, 9'h1ff}, 1, 3'b110, 9'h0f0, 9'h022},
    '{1'b0, 8'h34, {7'h00, 9'h123}, 2, 3'b111, 9'h000, 9'h000}};
  ctrl_host_model host (.clk_pin(scl), .data_drv(sda_drv), .latch_pin(latch), .data_line(sda));
  serial_control_and_jack_detect #(.TICK_LOG2(4)) dut (.ref_clk(ref_clk), .rst(rst),
    .mode_pin(mode_pin), .ctrl_clk_pin(scl), .ctrl_data_pin(sda), .ctrl_data_out(),
    .ctrl_data_oe(oe), .latch_or_io_one_pin(mode_pin ? latch : pin_one),
    .line_in_detect_pin(line_in), .io_pin_two(pin_two), .spk_normal_en(spk_n),
    .mono_normal_en(mono_n), .midrail_normal_en(mid_n), .speaker_output_en(spk),
    .mono_output_en(mono), .midrail_reference_en(mid), .jack_detect_config(r9),
    .jack_state_output_enables(r13), .io_low_config(io_low), .jack_level(lvl));
  // ----
  // Bench.
  // ----
  always #2 ref_clk = ~ref_clk;
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] w);
    host.write2(8'h34, w, 2, acks);
    tick(20);
  endtask
  function automatic logic [8:0] outs();
    return {5'h00, spk, mono, mid, lvl};
  endfunction
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    tick(20);
    rst = 1'b0;
    tick(4);
    foreach (rows[i]) begin
      mode_pin = rows[i].m;
      tick(8);
      acks = 3'b000;
      if (rows[i].m) host.write3(rows[i].w);
      else host.write2(rows[i].ba, rows[i].w, rows[i].n, acks);
      tick(20);
      check({6'h00, acks}, {6'h00, rows[i].ea});
      check(r9, rows[i].e9);
      check(r13, rows[i].e13);
    end
    wr({7'h08, 9'h0a5});
    check(io_low, 9'h0a5);
    wr({7'h09, 9'h150});
    wr({7'h0d, 9'h042});
    tick(100);
    check(outs(), 9'h008);
    line_in = 1'b1;
    tick(100);
    check(outs(), 9'h007);
    line_in = 1'b0;
    tick(2);
    line_in = 1'b1;
    tick(100);
    check(outs(), 9'h007);
    wr({7'h09, 9'h178});
    tick(100);
    check(outs(), 9'h008);
    pin_one = 1'b1;
    wr({7'h09, 9'h148});
    tick(100);
    check(outs(), 9'h007);
    spk_n = 1'b0;
    mid_n = 1'b1;
    wr({7'h09, 9'h000});
    check({outs()} & 9'h00e, 9'h006);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(4);
    check(r13, 9'h000);
    report_and_stop();
  end
endmodule
